// File: core/hpp_pkg.sv
package hpp_pkg;
    // register byte addresses (8-bit register space, index form)
    localparam logic [7:0] ADDR_DATA_PORT = 8'h08;
    localparam logic [7:0] ADDR_STROBE_PORT = 8'h09;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_STATUS_DIR = 8'h89;
    localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hF0;
    localparam logic [7:0] ADDR_DATA_DIR = 8'h88;
    // status/direction field positions
    localparam int BIT_IN_PEND = 7;
    localparam int BIT_OUT_PEND = 6;
    localparam int BIT_IN_OVR = 5;
    localparam int BIT_HOST_SEL = 4;
    localparam int BIT_DIR_SELECT = 2;
    localparam int BIT_DIR_STORE = 1;
    localparam int BIT_DIR_FETCH = 0;
    // interrupt flag position
    localparam int BIT_XFER_FLAG = 7;
    // reset values
    localparam logic [2:0] RST_STROBE_DIR = 3'h7;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [2:0] RST_STROBE_OUT = 3'h0;
    localparam logic [7:0] RST_DATA_DIR = 8'hFF;
endpackage

// File: core/hpp_strobe_detect.sv
`timescale 1ns/1ps
// turns the host strobes into a fetch access level and one-cycle end-of-access events
module hpp_strobe_detect (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic select_n,
    input wire logic fetch_n,
    input wire logic store_n,
    output logic read_active,
    output logic read_done,
    output logic write_done
);
    logic rd_q; // fetch access seen last cycle
    logic wr_q; // store access seen last cycle
    wire rd_now = enable && !select_n && !fetch_n;
    wire wr_now = enable && !select_n && !store_n;

    // register the access levels; an access ends on its trailing edge
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_now;
            wr_q <= wr_now;
        end
    end

    assign read_active = rd_now;
    assign read_done = rd_q && !rd_now;
    assign write_done = wr_q && !wr_now;
endmodule

// File: core/hpp_top.sv
`timescale 1ns/1ps
// What this block does
// - bit 4 selects host port mode
// - bit 7 flags unread host-written byte
// - bit 6 flags unread CPU-written byte
// - bit 5 sticky overrun on write-while-full
// - bit 3 always reads zero
// - bits 2..0 set strobe pin directions outside host mode
// - reset clears flags, sets directions to one
// - data port is GPIO or host bus
// - fetch pin is host read control
// - store pin is host write control
// - select pin qualifies every host access
module hpp_top (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    output logic IRQ,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic [7:0] DATA_OE_N,
    input wire logic [2:0] STROBE_IN,
    output logic [2:0] STROBE_OUT,
    output logic [2:0] STROBE_OE_N
);
    // the two byte latches of the data port
    logic [7:0] out_latch_q; // latch written by the CPU
    logic [7:0] in_latch_q; // latch written by the host
    // general purpose view of the pins
    logic [7:0] data_dir_q; // gpio direction of the data port, 1 = input
    logic [2:0] strobe_out_q; // gpio levels for the strobe pins
    logic [2:0] strobe_dir_q; // 1 = input
    // fields of the status/direction register
    logic host_sel_q; // 1 = data port serves the external master
    logic in_pend_q; // host byte waits for the CPU
    logic out_pend_q; // CPU byte waits for the host
    logic in_ovr_q; // host wrote over an unread byte
    // interrupt state
    logic [7:0] irq_flags_q; // sticky events
    logic [7:0] irq_en_q; // one enable per flag
    logic irq_q; // registered interrupt level
    // output flops; every top output except IRQ (from irq_q) comes straight from one of these
    logic [7:0] rdata_q; // read data, zero outside the answer cycle
    logic [7:0] data_out_q; // data pin drive
    logic [7:0] data_oe_n_q; // data pin enables, low = drive
    logic [2:0] strobe_oe_n_q; // strobe pin enables, low = drive
    logic [2:0] strobe_out_pin_q; // strobe pin drive

    // fetch access level and end-of-access events from the strobe detector
    logic host_read_active; // in host mode, select and fetch both low now
    logic host_read_done; // a fetch access ended this cycle
    logic host_write_done; // a store access ended this cycle

    // address compare used by every register select
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // host handshake timing, one clock per step:
    // the strobe pins are sampled straight, being synchronous to the clock;
    // an access is select low together with fetch or store low;
    // the detector registers the access level and flags its trailing edge;
    // a write takes the bus byte at that trailing edge, so the master must
    // keep the byte on the bus for one clock after it releases store;
    // a read turns the data drivers on one clock after the access is seen
    // and off one clock after it ends, so the master samples late in it.
    // limitation: an access that spans no clock edge may be missed, and two
    // accesses with no idle clock between them merge into one
    // strobe pins are fetch, store, select on bits 0, 1, 2
    hpp_strobe_detect u_det (
        .clk(SYS_CLK),
        .rst(RESET),
        .enable(host_sel_q),
        .select_n(STROBE_IN[hpp_pkg::BIT_DIR_SELECT]),
        .fetch_n(STROBE_IN[hpp_pkg::BIT_DIR_FETCH]),
        .store_n(STROBE_IN[hpp_pkg::BIT_DIR_STORE]),
        .read_active(host_read_active),
        .read_done(host_read_done),
        .write_done(host_write_done)
    );

    // register selects, shared by the write side and the read side
    wire sel_data = addr_hit(ADDR, hpp_pkg::ADDR_DATA_PORT); // data port
    wire sel_strobe = addr_hit(ADDR, hpp_pkg::ADDR_STROBE_PORT); // strobe pin port
    wire sel_flags = addr_hit(ADDR, hpp_pkg::ADDR_IRQ_FLAGS); // interrupt flags
    wire sel_stat = addr_hit(ADDR, hpp_pkg::ADDR_STATUS_DIR); // status and strobe directions
    wire sel_en = addr_hit(ADDR, hpp_pkg::ADDR_IRQ_ENABLES); // interrupt enables
    wire sel_clr = addr_hit(ADDR, hpp_pkg::ADDR_IRQ_CLEAR); // write-only flag clear
    wire sel_dir = addr_hit(ADDR, hpp_pkg::ADDR_DATA_DIR); // write-only data direction
    // strobes qualified by their register
    wire wr_data = WR_STB && sel_data;
    wire wr_strobe = WR_STB && sel_strobe;
    wire wr_stat = WR_STB && sel_stat;
    wire wr_en = WR_STB && sel_en;
    wire wr_clr = WR_STB && sel_clr;
    wire wr_dir = WR_STB && sel_dir;
    wire rd_data = RD_STB && sel_data;
    // host write is latched at its trailing edge; the bus must still hold the byte
    wire host_wr = host_write_done;
    wire host_rd = host_read_done;

    // status word; bit 3 is unimplemented and reads zero
    wire [7:0] status_word = {in_pend_q, out_pend_q, in_ovr_q, host_sel_q, 1'b0, strobe_dir_q};

    // data port read: host byte in host mode, pin levels otherwise
    wire [7:0] data_read = host_sel_q ? in_latch_q : DATA_IN;

    // strobe port read: pin levels, upper bits zero
    wire [7:0] strobe_read = {5'h00, STROBE_IN};

    // read mux; unmapped addresses and the clear register read zero
    // the direction register is write-only; software keeps its own copy
    wire [7:0] rd_mux =
        sel_data ? data_read :
        sel_strobe ? strobe_read :
        sel_flags ? irq_flags_q :
        sel_stat ? status_word :
        sel_en ? irq_en_q : 8'h00;

    // events and their set-over-clear next values
    wire [7:0] irq_evt = (host_wr || host_rd) ? (8'h01 << hpp_pkg::BIT_XFER_FLAG) : 8'h00;
    wire [7:0] clr_mask = wr_clr ? WDATA : 8'h00;
    wire [7:0] irq_flags_d = (irq_flags_q & ~clr_mask) | irq_evt; // set wins
    // software may clear overrun by writing 0; a new overrun wins
    wire ovr_set = host_wr && in_pend_q;
    wire ovr_clr = wr_stat && !WDATA[hpp_pkg::BIT_IN_OVR];
    // pending flags: the setting party wins in a tie
    wire in_pend_d = host_wr ? 1'b1 : (rd_data && host_sel_q) ? 1'b0 : in_pend_q;
    wire out_pend_d = (wr_data && host_sel_q) ? 1'b1 : host_rd ? 1'b0 : out_pend_q;

    // pin drivers: host mode drives data only during a host read
    wire [7:0] data_oe_n_d = host_sel_q ? (host_read_active ? 8'h00 : 8'hFF) : data_dir_q;
    // host mode forces the strobe pins to inputs
    wire [2:0] strobe_oe_n_d = host_sel_q ? 3'h7 : strobe_dir_q;

    // mode and strobe directions: the writable part of the status/direction register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            host_sel_q <= 1'b0;
            strobe_dir_q <= hpp_pkg::RST_STROBE_DIR;
        end else if (wr_stat) begin
            host_sel_q <= WDATA[hpp_pkg::BIT_HOST_SEL];
            strobe_dir_q <= WDATA[2:0];
        end
    end

    // pending flags are read-only to software; only the two data paths move them
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            in_pend_q <= 1'b0;
            out_pend_q <= 1'b0;
        end else begin
            in_pend_q <= in_pend_d;
            out_pend_q <= out_pend_d;
        end
    end

    // overrun stays set until software writes a 0 to it; a new overrun in
    // the same cycle as that write wins, so no lost byte goes unreported
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            in_ovr_q <= 1'b0;
        end else begin
            in_ovr_q <= ovr_set ? 1'b1 : (ovr_clr ? 1'b0 : in_ovr_q);
        end
    end

    // data latches and the strobe pin gpio levels
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            out_latch_q <= hpp_pkg::RST_DATA;
            in_latch_q <= hpp_pkg::RST_DATA;
            strobe_out_q <= hpp_pkg::RST_STROBE_OUT;
        end else begin
            if (wr_data) begin
                out_latch_q <= WDATA;
            end
            if (host_write_done) begin
                in_latch_q <= DATA_IN;
            end
            if (wr_strobe) begin
                strobe_out_q <= WDATA[2:0];
            end
        end
    end

    // gpio direction of the data port, kept in a register of its own
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            data_dir_q <= hpp_pkg::RST_DATA_DIR; // all inputs so nothing fights at power-up
        end else if (wr_dir) begin
            data_dir_q <= WDATA;
        end
    end

    // next enables, and the interrupt level built from next values so that
    // the output follows a flag or enable change with no extra cycle of lag
    wire [7:0] irq_en_d = wr_en ? WDATA : irq_en_q;
    wire irq_d = |(irq_flags_d & irq_en_d);

    // sticky event flags; set wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_flags_q <= hpp_pkg::RST_IRQ;
        end else begin
            irq_flags_q <= irq_flags_d;
        end
    end

    // interrupt enables
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_en_q <= hpp_pkg::RST_IRQ;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // level interrupt output, high while an enabled flag is set
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // read data stand only in the cycle after the strobe and are zero
    // otherwise, so a late sample can never pick up a stale byte
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= RD_STB ? rd_mux : 8'h00;
        end
    end

    // pin flops; drive values follow a write at the same edge, so the pins
    // never show the old latch for an extra cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            data_out_q <= hpp_pkg::RST_DATA;
            data_oe_n_q <= 8'hFF;
            strobe_oe_n_q <= 3'h7;
            strobe_out_pin_q <= hpp_pkg::RST_STROBE_OUT;
        end else begin
            data_out_q <= wr_data ? WDATA : out_latch_q;
            data_oe_n_q <= data_oe_n_d;
            strobe_oe_n_q <= strobe_oe_n_d;
            strobe_out_pin_q <= wr_strobe ? WDATA[2:0] : strobe_out_q;
        end
    end

    assign RDATA = rdata_q;
    assign IRQ = irq_q;
    assign DATA_OUT = data_out_q;
    assign DATA_OE_N = data_oe_n_q;
    assign STROBE_OUT = strobe_out_pin_q;
    assign STROBE_OE_N = strobe_oe_n_q;
endmodule

// File: verification/hpp_properties.sv
`timescale 1ns/1ps
// pin and bus relations of the host port block
module hpp_properties (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic [7:0] DATA_OUT,
    input wire logic [7:0] DATA_OE_N,
    input wire logic [2:0] STROBE_IN,
    input wire logic [2:0] STROBE_OE_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // a lone data port write, so the latch is not overwritten before we look
    sequence data_wr;
        WR_STB && ADDR == 8'h08 ##1 !(WR_STB && ADDR == 8'h08);
    endsequence
    a_reset_state: assert property ($past(RESET) |-> STROBE_OE_N == 3'h7 && DATA_OE_N == 8'hFF)
        else $error("pin state after reset wrong");
    a_rdata_quiet: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (RD_STB && ADDR == 8'h55 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_gap_bit_zero: assert property (RD_STB && ADDR == 8'h89 |=> !RDATA[3])
        else $error("status bit 3 set");
    a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(WR_STB) || $past(WR_STB, 2) || $past(WR_STB, 3))
        else $error("interrupt dropped without a write");
    a_strobe_dir: assert property (WR_STB && ADDR == 8'h89 |-> ##2
        STROBE_OE_N == ($past(WDATA[4], 2) ? 3'h7 : $past(WDATA[2:0], 2))) else $error("strobe direction wrong");
    a_data_latch: assert property (data_wr |=> DATA_OUT == $past(WDATA, 2))
        else $error("data latch not loaded");
    // the data drivers only move after a register write or a strobe change
    a_oe_cause: assert property ($changed(DATA_OE_N) |-> $past(WR_STB) || $past(WR_STB, 2) ||
        $past(STROBE_IN) != $past(STROBE_IN, 2) || $past(STROBE_IN, 2) != $past(STROBE_IN, 3))
        else $error("data drive changed without cause");
endmodule

// File: verification/hpp_host_model.sv
`timescale 1ns/1ps
// external master: strobes active low, idle high
module hpp_host_model (
    input wire logic clk,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] dout,
    output logic [2:0] stb_n,
    output logic [7:0] bus
);
    logic drv = 1'b0;
    logic [7:0] hd = 8'h00;
    logic [7:0] pat = 8'h5A;
    initial stb_n = 3'h7;
    // a released bus toggles, so a stale byte never looks valid
    always @(posedge clk) pat <= ~pat;
    assign bus = (~oe_n & dout) | (oe_n & (drv ? hd : pat));
    // select with store for two edges, data held one edge past release
    task automatic hwrite(input logic [7:0] b);
        @(posedge clk);
        stb_n <= 3'h1;
        hd <= b;
        drv <= 1'b1;
        repeat (2) @(posedge clk);
        stb_n <= 3'h7;
        @(posedge clk);
        drv <= 1'b0;
    endtask
    // select with fetch, byte taken at the edge that ends the access
    task automatic hread(output logic [7:0] v);
        @(posedge clk);
        stb_n <= 3'h2;
        repeat (3) @(posedge clk);
        v = bus;
        stb_n <= 3'h7;
    endtask
endmodule

// File: verification/hpp_top_tb.sv
`timescale 1ns/1ps
module hpp_top_tb;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
    logic WR_STB = 1'b0, RD_STB = 1'b0, IRQ;
    logic [7:0] RDATA, DATA_IN, DATA_OUT, DATA_OE_N, v;
    logic [2:0] STROBE_IN, STROBE_OUT, STROBE_OE_N, hstb;
    int miscompares = 0;
    int n_checks = 0;
    // a strobe pin set as output shows the block's own drive
    assign STROBE_IN = (~STROBE_OE_N & STROBE_OUT) | (STROBE_OE_N & hstb);
    hpp_top uut (.SYS_CLK, .RESET, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .IRQ, .DATA_IN, .DATA_OUT,
        .DATA_OE_N, .STROBE_IN, .STROBE_OUT, .STROBE_OE_N);
    hpp_host_model host (.clk(SYS_CLK), .oe_n(DATA_OE_N), .dout(DATA_OUT), .stb_n(hstb), .bus(DATA_IN));
    initial forever #4 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; a read compares the byte in the cycle after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= w;
        RD_STB <= !w;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b0;
        #1 if (!w) chk(RDATA, d);
    endtask
    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge SYS_CLK);
        RESET <= 1'b0;
        acc(0, 8'h89, 8'h07);
        acc(0, 8'h0C, 8'h00);
        acc(1, 8'h55, 8'hFF);
        acc(0, 8'h55, 8'h00);
        // general purpose mode: pins driven, then read back
        acc(1, 8'h88, 8'h00);
        acc(1, 8'h08, 8'h3C);
        chk(DATA_OE_N, 8'h00);
        acc(0, 8'h08, 8'h3C);
        acc(1, 8'h09, 8'h00);
        acc(1, 8'h89, 8'h03);
        acc(0, 8'h09, 8'h03);
        chk({5'h00, STROBE_OE_N}, 8'h03);
        acc(1, 8'h09, 8'h04);
        acc(0, 8'h09, 8'h07);
        acc(1, 8'h89, 8'hFF);
        acc(0, 8'h89, 8'h17);
        acc(0, 8'h09, 8'h07);
        // host writes while the interrupt is masked, then enabled
        host.hwrite(8'h5A);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({7'h00, IRQ}, 8'h00);
        acc(0, 8'h89, 8'h97);
        acc(1, 8'h8C, 8'h80);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({7'h00, IRQ}, 8'h01);
        host.hwrite(8'hC3);
        acc(0, 8'h89, 8'hB7);
        acc(0, 8'h08, 8'hC3);
        acc(0, 8'h89, 8'h37);
        acc(1, 8'h89, 8'hDF);
        acc(0, 8'h89, 8'h17);
        acc(1, 8'hF0, 8'h80);
        acc(0, 8'h0C, 8'h00);
        chk({7'h00, IRQ}, 8'h00);
        // cpu byte fetched by the host
        acc(1, 8'h08, 8'h69);
        acc(0, 8'h89, 8'h57);
        host.hread(v);
        chk(v, 8'h69);
        acc(0, 8'h89, 8'h17);
        acc(0, 8'h0C, 8'h80);
        // strobes ignored once host mode is off
        acc(1, 8'h89, 8'h07);
        host.hwrite(8'hEE);
        acc(0, 8'h89, 8'h07);
        // second reset in mid-run, with host mode on and the interrupt high
        acc(1, 8'h89, 8'h10);
        @(posedge SYS_CLK);
        RESET <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RESET <= 1'b0;
        acc(0, 8'h89, 8'h07);
        acc(0, 8'h0C, 8'h00);
        acc(0, 8'h8C, 8'h00);
        chk({7'h00, IRQ}, 8'h00);
        chk(DATA_OE_N, 8'hFF);
        stop_test();
    end
endmodule
bind hpp_top hpp_properties props (.SYS_CLK, .RESET, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .IRQ,
    .DATA_OUT, .DATA_OE_N, .STROBE_IN, .STROBE_OE_N);
